// ### rtl/ltl_flash_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ltl_flash_mem
  import ltl_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic                  we_i,
  input  wire logic [LTL_MEM_AW-1:0] addr_i,
  input  wire logic [15:0]           wdata_i,
  output logic      [15:0]           rdata_o
);

  typedef struct packed {
    logic [15:0] rdata;
  } ltl_mem_state_t;

  ltl_mem_state_t s_reg;
  ltl_mem_state_t s_next;
  logic [15:0]    mem [LTL_MEM_DEPTH] = '{default: 16'h0000};

  // ---------------------------------------------------------------
  // nonvolatile array, blank at power up
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // registered read, write first
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rdata = we_i ? wdata_i : mem[addr_i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;

endmodule
`default_nettype wire

// ### rtl/ltl_logger.sv
`timescale 1ns/1ps
`default_nettype none
module ltl_logger
  import ltl_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = LTL_CYCLES_PER_SEC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        sealed_i,
  input  wire logic        meas_valid_i,
  input  wire logic [15:0] meas_volt_i,
  input  wire logic [15:0] meas_curr_i,
  input  wire logic [15:0] meas_temp_i
);

  typedef struct packed {
    ltl_state_t                          state;
    logic [2:0]                          cnt;
    logic                                prev_idle;
    logic                                learn_en;
    logic [15:0]                         interval;
    logic [LTL_N_PARAM-1:0][15:0]        res;
    logic [7:0]                          subclass;
    logic [7:0]                          blksel;
    logic [LTL_MEM_AW-1:0]               index;
    logic [LTL_TBL_N-1:0][15:0]          ram;
    logic [LTL_TBL_N-1:0][15:0]          df;
    logic                                win_open;
    logic [31:0]                         sec_cnt;
    logic [15:0]                         sec_left;
    logic                                pend;
    logic                                pend_wr;
    logic [7:0]                          pend_addr;
    logic [31:0]                         hrdata;
    logic                                hready;
    logic                                hresp;
  } ltl_state_s_t;

  ltl_state_s_t                 s_reg;
  ltl_state_s_t                 s_next;
  logic                         mem_we;
  logic [LTL_MEM_AW-1:0]        mem_addr;
  logic [15:0]                  mem_wdata;
  logic [15:0]                  mem_rdata;
  logic [LTL_N_PARAM-1:0][15:0] meas;
  logic                         active;
  logic                         qual;
  logic                         data_ok;
  logic                         res_ok;
  logic                         mem_free;
  logic [7:0]                   ram_sel;
  logic [31:0]                  rd_val;

  function automatic logic signed [17:0] sx(input logic [15:0] v);
    sx = $signed({v[15], v[15], v});
  endfunction

  function automatic logic signed [17:0] zx(input logic [15:0] v);
    zx = $signed({2'b00, v});
  endfunction

  assign meas = {meas_temp_i, meas_curr_i, meas_volt_i};

  // ---------------------------------------------------------------
  // flash array
  // ---------------------------------------------------------------
  ltl_flash_mem u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next    = s_reg;
    mem_we    = 1'b0;
    mem_addr  = s_reg.index;
    mem_wdata = hwdata_i[15:0];
    qual      = 1'b0;
    rd_val    = 32'h0000_0000;
    active    = s_reg.learn_en && (s_reg.interval != 16'h0000);
    mem_free  = (s_reg.state == LTL_S_IDLE) && s_reg.prev_idle;
    ram_sel   = s_reg.pend_addr - LTL_OFF_RAM0;
    if (sealed_i) begin
      data_ok = (s_reg.blksel == LTL_SEALED_BLOCK) &&
                (s_reg.index < LTL_SEALED_ENTRIES);
    end else begin
      data_ok = (s_reg.subclass == LTL_SUBCLASS_DATA);
    end
    res_ok = !sealed_i && (s_reg.subclass == LTL_SUBCLASS_RES);

    s_next.prev_idle = (s_reg.state == LTL_S_IDLE);

    // -------------------------------------------------------------
    // table load and flash copy
    // -------------------------------------------------------------
    unique case (s_reg.state)
      LTL_S_LOAD: begin
        mem_addr = {2'b00, s_reg.cnt};
        if (s_reg.cnt != 3'd0) begin
          s_next.ram[s_reg.cnt - 3'd1] = mem_rdata;
          s_next.df[s_reg.cnt - 3'd1]  = mem_rdata;
        end
        if (s_reg.cnt == LTL_LOAD_END) begin
          s_next.state = LTL_S_IDLE;
          s_next.cnt   = 3'd0;
        end else begin
          s_next.cnt = s_reg.cnt + 3'd1;
        end
      end
      LTL_S_IDLE: begin
      end
      LTL_S_COPY: begin
        mem_we    = 1'b1;
        mem_addr  = {2'b00, s_reg.cnt};
        mem_wdata = s_reg.ram[s_reg.cnt];
        s_next.df[s_reg.cnt] = s_reg.ram[s_reg.cnt];
        if (s_reg.cnt == LTL_TBL_LAST) begin
          s_next.state = LTL_S_IDLE;
          s_next.cnt   = 3'd0;
        end else begin
          s_next.cnt = s_reg.cnt + 3'd1;
        end
      end
    endcase

    // -------------------------------------------------------------
    // extreme tracking
    // -------------------------------------------------------------
    if (meas_valid_i && active && (s_reg.state != LTL_S_LOAD)) begin
      for (int p = 0; p < LTL_N_PARAM; p++) begin
        if (sx(meas[p]) > sx(s_reg.ram[2*p])) begin
          s_next.ram[2*p] = meas[p];
        end
        if (sx(meas[p]) < sx(s_reg.ram[2*p+1])) begin
          s_next.ram[2*p+1] = meas[p];
        end
        if ((sx(meas[p]) > sx(s_reg.df[2*p]) + zx(s_reg.res[p])) ||
            (sx(meas[p]) < sx(s_reg.df[2*p+1]) - zx(s_reg.res[p]))) begin
          qual = 1'b1;
        end
      end
    end

    // -------------------------------------------------------------
    // update window
    // -------------------------------------------------------------
    if (s_reg.win_open) begin
      if (s_reg.sec_cnt == 32'(CYC_PER_SEC - 1)) begin
        s_next.sec_cnt = 32'h0000_0000;
        if (s_reg.sec_left <= 16'h0001) begin
          s_next.win_open = 1'b0;
          s_next.state    = LTL_S_COPY;
          s_next.cnt      = 3'd0;
          s_next.sec_left = 16'h0000;
        end else begin
          s_next.sec_left = s_reg.sec_left - 16'h0001;
        end
      end else begin
        s_next.sec_cnt = s_reg.sec_cnt + 32'h0000_0001;
      end
    end else if (qual) begin
      s_next.win_open = 1'b1;
      s_next.sec_left = s_reg.interval;
      s_next.sec_cnt  = 32'h0000_0000;
    end

    // -------------------------------------------------------------
    // read mux
    // -------------------------------------------------------------
    case (s_reg.pend_addr)
      LTL_OFF_STATUS: begin
        rd_val[LTL_ST_LEARN_B]  = s_reg.learn_en;
        rd_val[LTL_ST_ACTIVE_B] = active;
        rd_val[LTL_ST_WIN_B]    = s_reg.win_open;
        rd_val[LTL_ST_BUSY_B]   = (s_reg.state != LTL_S_IDLE);
        rd_val[LTL_ST_SEALED_B] = sealed_i;
        rd_val[LTL_ST_LEFT_LSB +: 16] = s_reg.sec_left;
      end
      LTL_OFF_CMD:      rd_val       = 32'h0000_0000;
      LTL_OFF_INTERVAL: rd_val[15:0] = s_reg.interval;
      LTL_OFF_RES_VOLT: rd_val[15:0] = s_reg.res[0];
      LTL_OFF_RES_CURR: rd_val[15:0] = s_reg.res[1];
      LTL_OFF_RES_TEMP: rd_val[15:0] = s_reg.res[2];
      LTL_OFF_SUBCLASS: rd_val[7:0]  = s_reg.subclass;
      LTL_OFF_BLKSEL:   rd_val[7:0]  = s_reg.blksel;
      LTL_OFF_INDEX:    rd_val[LTL_MEM_AW-1:0] = s_reg.index;
      LTL_OFF_DATA: begin
        if (data_ok) begin
          rd_val[15:0] = mem_rdata;
        end
      end
      default: begin
        if (ram_sel < 8'(4 * LTL_TBL_N)) begin
          rd_val[15:0] = s_reg.ram[ram_sel[4:2]];
        end
      end
    endcase

    // -------------------------------------------------------------
    // ahb-lite slave
    // -------------------------------------------------------------
    s_next.hresp = 1'b0;
    if (s_reg.pend) begin
      if (mem_free) begin
        s_next.pend   = 1'b0;
        s_next.hready = 1'b1;
        if (!s_reg.pend_wr) begin
          s_next.hrdata = rd_val;
        end else begin
          case (s_reg.pend_addr)
            LTL_OFF_CMD: begin
              if (hwdata_i[15:0] == LTL_CMD_LEARN_EN) begin
                s_next.learn_en = 1'b1;
              end
            end
            LTL_OFF_INTERVAL: begin
              if (res_ok) begin
                s_next.interval = hwdata_i[15:0];
              end
            end
            LTL_OFF_RES_VOLT: begin
              if (res_ok) begin
                s_next.res[0] = hwdata_i[15:0];
              end
            end
            LTL_OFF_RES_CURR: begin
              if (res_ok) begin
                s_next.res[1] = hwdata_i[15:0];
              end
            end
            LTL_OFF_RES_TEMP: begin
              if (res_ok) begin
                s_next.res[2] = hwdata_i[15:0];
              end
            end
            LTL_OFF_SUBCLASS: s_next.subclass = hwdata_i[7:0];
            LTL_OFF_BLKSEL:   s_next.blksel   = hwdata_i[7:0];
            LTL_OFF_INDEX:    s_next.index    = hwdata_i[LTL_MEM_AW-1:0];
            LTL_OFF_DATA: begin
              // only the array changes; shadow and ram keep old values
              if (data_ok) begin
                mem_we = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end else if (hsel_i && htrans_i[1] && hready_i) begin
      s_next.pend      = 1'b1;
      s_next.pend_wr   = hwrite_i;
      s_next.pend_addr = {haddr_i[7:2], 2'b00};
      s_next.hready    = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg           <= '0;
      s_reg.state     <= LTL_S_LOAD;
      s_reg.cnt       <= 3'd0;
      s_reg.learn_en  <= 1'b0;
      s_reg.win_open  <= 1'b0;
      s_reg.pend      <= 1'b0;
      s_reg.interval  <= LTL_RST_INTERVAL;
      s_reg.res       <= {LTL_N_PARAM{LTL_RST_RES}};
      s_reg.subclass  <= LTL_RST_SUBCLASS;
      s_reg.blksel    <= LTL_RST_BLKSEL;
      s_reg.hready    <= 1'b1;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign hrdata_o    = s_reg.hrdata;
  assign hreadyout_o = s_reg.hready;
  assign hresp_o     = s_reg.hresp;

endmodule
`default_nettype wire

// ### rtl/ltl_pkg.sv
// Behaviour
// - logging idle until enable subcommand received
// - logging needs enable and nonzero interval
// - trigger only beyond stored extreme plus resolution
// - window of interval seconds, write at end
// - extremes inside open window join its write
// - next window opens on first later extreme
// - ram extremes follow every new extreme while logging is active
// - flash write copies entire ram table
// - host flash writes apply after next reset
// - unsealed host accesses data subclass fifty-nine
// - sealed host selects block four for access
// - sealed access limited to first 32 bytes
// - resolutions and interval writable only unsealed
package ltl_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] LTL_OFF_CMD      = 8'h00;
  localparam logic [7:0] LTL_OFF_STATUS   = 8'h04;
  localparam logic [7:0] LTL_OFF_INTERVAL = 8'h08;
  localparam logic [7:0] LTL_OFF_RES_VOLT = 8'h0c;
  localparam logic [7:0] LTL_OFF_RES_CURR = 8'h10;
  localparam logic [7:0] LTL_OFF_RES_TEMP = 8'h14;
  localparam logic [7:0] LTL_OFF_SUBCLASS = 8'h18;
  localparam logic [7:0] LTL_OFF_BLKSEL   = 8'h1c;
  localparam logic [7:0] LTL_OFF_INDEX    = 8'h20;
  localparam logic [7:0] LTL_OFF_DATA     = 8'h24;
  localparam logic [7:0] LTL_OFF_RAM0     = 8'h40;

  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int LTL_ST_LEARN_B  = 0;
  localparam int LTL_ST_ACTIVE_B = 1;
  localparam int LTL_ST_WIN_B    = 2;
  localparam int LTL_ST_BUSY_B   = 3;
  localparam int LTL_ST_SEALED_B = 4;
  localparam int LTL_ST_LEFT_LSB = 16;

  // ---------------------------------------------------------------
  // commands, subclasses, access limits
  // ---------------------------------------------------------------
  localparam logic [15:0] LTL_CMD_LEARN_EN    = 16'h0021;
  localparam logic [7:0]  LTL_SUBCLASS_DATA   = 8'h3b;
  localparam logic [7:0]  LTL_SUBCLASS_RES    = 8'h42;
  localparam logic [7:0]  LTL_SEALED_BLOCK    = 8'h04;
  localparam int          LTL_SEALED_BYTES    = 32;
  localparam logic [4:0]  LTL_SEALED_ENTRIES  = 5'(LTL_SEALED_BYTES / 2);

  // ---------------------------------------------------------------
  // table geometry
  // ---------------------------------------------------------------
  localparam int          LTL_N_PARAM  = 3;
  localparam int          LTL_TBL_N    = 2 * LTL_N_PARAM;
  localparam logic [2:0]  LTL_TBL_LAST = 3'(LTL_TBL_N - 1);
  localparam logic [2:0]  LTL_LOAD_END = 3'(LTL_TBL_N);
  localparam int          LTL_MEM_AW   = 5;
  localparam int          LTL_MEM_DEPTH = 32;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] LTL_RST_INTERVAL = 16'h0000;
  localparam logic [15:0] LTL_RST_RES      = 16'h0000;
  localparam logic [7:0]  LTL_RST_SUBCLASS = 8'h00;
  localparam logic [7:0]  LTL_RST_BLKSEL   = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int LTL_TICK_S         = 1;
  localparam int LTL_CLK_HZ         = 40_000_000;
  localparam int LTL_CYCLES_PER_SEC = LTL_TICK_S * LTL_CLK_HZ;

  typedef enum logic [2:0] {
    LTL_S_LOAD = 3'b001,
    LTL_S_IDLE = 3'b010,
    LTL_S_COPY = 3'b100
  } ltl_state_t;

endpackage

// ### verif/ltl_host.sv
`timescale 1ns/1ps
`default_nettype none
module ltl_host
  import ltl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  // ---------------------------------------------------------------
  // single word transfers, lines inverted once released
  // ---------------------------------------------------------------
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= {24'h0, a};
    hwrite_o <= w;
    htrans_o <= 2'b10;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    haddr_o <= ~{24'h0, a};
    hwdata_o <= w ? d : ~hwdata_o;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hwdata_o <= ~hwdata_o;
  endtask
endmodule
`default_nettype wire

// ### verif/ltl_logger_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ltl_logger_chk
  import ltl_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = LTL_CYCLES_PER_SEC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_o,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic        sealed_i
);
  // ---------------------------------------------------------------
  // data phase tracking
  // ---------------------------------------------------------------
  logic       pend_q;
  logic       rd_q;
  logic [7:0] adr_q;
  logic       take;
  logic       done;
  assign take = hsel_i && htrans_i[1] && hready_i;
  assign done = pend_q && hreadyout_o && rd_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 8'h00;
    end else if (hreadyout_o) begin
      pend_q <= take;
      rd_q <= take && !hwrite_i;
      adr_q <= haddr_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_okay_a: assert property (!hresp_o)
    else $error("error response seen");
  wait_state_a: assert property (take |=> !hreadyout_o)
    else $error("no wait state after transfer");
  ready_bound_a: assert property (!hreadyout_o |-> ##[1:40] hreadyout_o)
    else $error("transfer never completes");
  stall_cause_a: assert property (!hreadyout_o |-> pend_q)
    else $error("stall without transfer");
  rdata_hold_a: assert property ($changed(hrdata_o) |-> done)
    else $error("read data changed outside read");
  reset_idle_a: assert property ($fell(rst_i) |-> hreadyout_o && hrdata_o == 32'h0)
    else $error("bus outputs not idle after reset");
  cmd_zero_a: assert property (done && adr_q == LTL_OFF_CMD |-> hrdata_o == 32'h0)
    else $error("command register read nonzero");
  active_learn_a: assert property (done && adr_q == LTL_OFF_STATUS |->
    !(hrdata_o[LTL_ST_ACTIVE_B] && !hrdata_o[LTL_ST_LEARN_B])) else $error("active without enable");
  sealed_flag_a: assert property (done && adr_q == LTL_OFF_STATUS |->
    hrdata_o[LTL_ST_SEALED_B] == sealed_i) else $error("sealed flag wrong");
  unmapped_zero_a: assert property (done && adr_q >= 8'h58 |-> hrdata_o == 32'h0)
    else $error("unmapped read nonzero");

  cover property (take && hwrite_i);
  cover property (done && adr_q == LTL_OFF_STATUS && hrdata_o[LTL_ST_WIN_B]);
  cover property (done && adr_q == LTL_OFF_DATA && sealed_i);
endmodule

bind ltl_logger ltl_logger_chk #(.CYC_PER_SEC(CYC_PER_SEC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .sealed_i(sealed_i));
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ltl_pkg::*;
;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} ltl_exp_t;
  // ---------------------------------------------------------------
  // clock, reset, host, checking queue
  // ---------------------------------------------------------------
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               sealed = 1'b0;
  logic               mv = 1'b0;
  logic [15:0]        mvv = 16'h0;
  logic [15:0]        mvc = 16'h0;
  logic [15:0]        mvt = 16'h0;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic               hready;
  logic               hresp;
  logic               mon_rd = 1'b0;
  ltl_exp_t           q[$];
  ltl_exp_t           x;
  int                 n_errors = 0;
  int                 samples_checked = 0;
  int                 cyc = 0;
  logic [15:0]        f1 [6] = '{16'h0033, 16'hffec, 16'h0, 16'h0, 16'h0005, 16'h0};
  logic [15:0]        vals [3];
  logic signed [15:0] mx [3];
  logic signed [15:0] mn [3];

  always #12.5 clk = ~clk;

  ltl_logger #(.CYC_PER_SEC(10)) DUT (
    .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .sealed_i(sealed), .meas_valid_i(mv), .meas_volt_i(mvv), .meas_curr_i(mvc),
    .meas_temp_i(mvt));

  ltl_host host (
    .clk_i(clk), .hready_i(hready), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  task automatic end_sim;
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    q.push_back(ltl_exp_t'{e, m});
    host.xfer(1'b0, a, 32'h0);
  endtask

  task automatic smp(input logic [15:0] v, input logic [15:0] c, input logic [15:0] t);
    @(posedge clk);
    mv <= 1'b1;
    mvv <= v;
    mvc <= c;
    mvt <= t;
    @(posedge clk);
    mv <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (mon_rd && hready === 1'b1) begin
      mon_rd <= 1'b0;
      x = q.pop_front();
      samples_checked++;
      if ((hrdata & x.m) !== (x.e & x.m)) begin
        n_errors++;
        $display("BAD %0t exp %h got %h", $time, x.e & x.m, hrdata & x.m);
      end
    end
    if (hsel && htrans[1] && hready && !hwrite) mon_rd <= 1'b1;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(21642));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(LTL_OFF_STATUS, 32'h0, 32'h1f);
    rdc(LTL_OFF_CMD, 32'h0);
    for (int i = 0; i < 6; i++) rdc(8'(LTL_OFF_RAM0 + 4 * i), 32'h0);
    wr(LTL_OFF_INTERVAL, 32'h2);
    rdc(LTL_OFF_INTERVAL, 32'h0);
    wr(LTL_OFF_SUBCLASS, 32'(LTL_SUBCLASS_RES));
    sealed <= 1'b1;
    wr(LTL_OFF_INTERVAL, 32'h2);
    rdc(LTL_OFF_INTERVAL, 32'h0);
    sealed <= 1'b0;
    wr(LTL_OFF_INTERVAL, 32'h2);
    smp(16'h9, 16'h0, 16'h0);
    rdc(LTL_OFF_RAM0, 32'h0);
    rdc(LTL_OFF_STATUS, 32'h0, 32'h3);
    wr(LTL_OFF_INTERVAL, 32'h0);
    wr(LTL_OFF_CMD, 32'(LTL_CMD_LEARN_EN));
    rdc(LTL_OFF_STATUS, 32'h1, 32'h3);
    smp(16'h9, 16'h0, 16'h0);
    rdc(LTL_OFF_RAM0, 32'h0);
    wr(LTL_OFF_RES_VOLT, 32'd50);
    wr(LTL_OFF_RES_CURR, 32'd100);
    wr(LTL_OFF_RES_TEMP, 32'd100);
    wr(LTL_OFF_INTERVAL, 32'h2);
    rdc(LTL_OFF_STATUS, 32'h3, 32'h3);
    wr(LTL_OFF_SUBCLASS, 32'(LTL_SUBCLASS_DATA));
    wr(LTL_OFF_INDEX, 32'h0);
    smp(16'd50, 16'h0, 16'h5);
    rdc(LTL_OFF_STATUS, 32'h0, 32'h4);
    rdc(LTL_OFF_RAM0, 32'd50);
    smp(16'd51, 16'h0, 16'h0);
    rdc(LTL_OFF_STATUS, 32'h4, 32'h4);
    smp(16'hffec, 16'h0, 16'h0);
    rdc(LTL_OFF_DATA, 32'h0);
    repeat (40) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      wr(LTL_OFF_INDEX, 32'(i));
      rdc(LTL_OFF_DATA, {16'h0, f1[i]});
    end
    smp(16'd60, 16'h0, 16'h0);
    rdc(LTL_OFF_STATUS, 32'h0, 32'h4);
    rdc(LTL_OFF_RAM0, 32'd60);
    smp(16'd200, 16'h0, 16'h0);
    rdc(LTL_OFF_STATUS, 32'h4, 32'h4);
    repeat (40) @(posedge clk);
    wr(LTL_OFF_INDEX, 32'h0);
    rdc(LTL_OFF_DATA, 32'd200);
    wr(LTL_OFF_DATA, 32'h0123);
    rdc(LTL_OFF_DATA, 32'h0123);
    rdc(LTL_OFF_RAM0, 32'd200);
    wr(LTL_OFF_INDEX, 32'(LTL_SEALED_ENTRIES));
    wr(LTL_OFF_DATA, 32'h0abc);
    rdc(LTL_OFF_DATA, 32'h0abc);
    sealed <= 1'b1;
    wr(LTL_OFF_BLKSEL, 32'(LTL_SEALED_BLOCK));
    wr(LTL_OFF_INDEX, 32'h4);
    rdc(LTL_OFF_DATA, 32'h5);
    wr(LTL_OFF_DATA, 32'h0777);
    rdc(LTL_OFF_DATA, 32'h0777);
    wr(LTL_OFF_INDEX, 32'(LTL_SEALED_ENTRIES));
    rdc(LTL_OFF_DATA, 32'h0);
    wr(LTL_OFF_INDEX, 32'h4);
    wr(LTL_OFF_BLKSEL, 32'h0);
    rdc(LTL_OFF_DATA, 32'h0);
    wr(LTL_OFF_SUBCLASS, 32'(LTL_SUBCLASS_RES));
    wr(LTL_OFF_INTERVAL, 32'h9);
    rdc(LTL_OFF_INTERVAL, 32'h2);
    rdc(8'h80, 32'h0);
    sealed <= 1'b0;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(LTL_OFF_STATUS, 32'h0, 32'h3);
    rdc(LTL_OFF_RAM0, 32'h0123);
    wr(LTL_OFF_SUBCLASS, 32'(LTL_SUBCLASS_RES));
    wr(LTL_OFF_INTERVAL, 32'h1);
    wr(LTL_OFF_CMD, 32'(LTL_CMD_LEARN_EN));
    mx = '{16'h0123, 16'h0, 16'h0777};
    mn = '{16'hffec, 16'h0, 16'h0};
    for (int n = 0; n < 24; n++) begin
      for (int k = 0; k < 3; k++) begin
        vals[k] = 16'($urandom);
        if ($signed(vals[k]) > mx[k]) mx[k] = vals[k];
        if ($signed(vals[k]) < mn[k]) mn[k] = vals[k];
      end
      smp(vals[0], vals[1], vals[2]);
    end
    for (int i = 0; i < 6; i++)
      rdc(8'(LTL_OFF_RAM0 + 4 * i), {16'h0, (i % 2) ? mn[i / 2] : mx[i / 2]});
    repeat (5) @(posedge clk);
    if (q.size() != 0) n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
